/* src/reset_seq_pkg.sv */
// Constants for the power-on and supply-fail reset sequencer.
// Assumes a 40 MHz system clock; times are converted to cycles here.
package reset_seq_pkg;

  // System clock period
  localparam int unsigned CLK_PERIOD_NS = 25;

  // Power-on release delay, typical upper figure
  localparam int unsigned RELEASE_DELAY_US = 300;
  localparam int unsigned RELEASE_DELAY_CYC = (RELEASE_DELAY_US * 1000) / CLK_PERIOD_NS;

  // Delay counter width
  localparam int unsigned DELAY_W = 16;

  // Reset cause register layout
  localparam int unsigned CAUSE_W        = 8;
  localparam int unsigned POWER_ON_BIT   = 1;
  localparam int unsigned CAUSE_OTHER_LO = 2;
  localparam logic [7:0]  CAUSE_RESET    = 8'h02;

  // Restart program address
  localparam logic [15:0] RESTART_ADDR = 16'h0000;

  // Supply monitor enable after power-on
  localparam logic MONITOR_EN_RESET = 1'b0;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_POWER_UP = 2'b00,
    ST_DELAY    = 2'b01,
    ST_RUN      = 2'b10,
    ST_HOLD     = 2'b11
  } seq_state_e;

endpackage

/* src/release_timer.sv */
// Release delay counter for the reset sequencer.
// Assumes run_in is held high while counting is wanted.
`timescale 1ns/10ps
module release_timer #(
  parameter int unsigned DELAY_CYC = reset_seq_pkg::RELEASE_DELAY_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic run_in,
  output logic      done_out
);

  logic [reset_seq_pkg::DELAY_W-1:0] count_reg;

  // Count while run is high, clear otherwise
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= '0;
      done_out  <= 1'b0;
    end else if (!run_in) begin
      count_reg <= '0;
      done_out  <= 1'b0;
    end else if (count_reg == reset_seq_pkg::DELAY_W'(DELAY_CYC - 1)) begin
      done_out <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

endmodule

/* src/power_on_and_supply_fail_reset.sv */
// Power-on and supply-fail reset sequencer.
// Assumes synchronous comparator input, a power-on strobe from the analog side,
// and a generic other-reset event from the rest of the chip.
// Outputs come straight from flip-flops; rst_in alone is the power-on event.
//
// Summary of operation
// - Hold core reset and drive reset pin low until supply above threshold.
// - After threshold crossing, wait the power-on release delay before releasing.
// - Set the power-on flag, cause bit 1, on leaving power-on reset.
// - While power-on flag set, other cause bits are indeterminate.
// - Any non-power-on reset clears the power-on flag, except one in the same cycle as the power-on exit.
// - On every reset release, fetch restarts at address zero.
// - Supply monitor enable comes up disabled after power-on reset.
// - Data memory gets no guaranteed value after power-on reset.
// - With the monitor enabled, supply drop below threshold asserts reset; recovery above releases it.
// - Supply-fail reset leaves data memory contents untouched.
`timescale 1ns/10ps
module power_on_and_supply_fail_reset (
  // Clock and power-on reset (rst_in is the power-on event)
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Analog comparator: supply above supply_reset_threshold
  input  wire logic        supply_ok_in,
  // Other reset sources, one-cycle pulse, with cause bits
  input  wire logic        other_reset_in,
  input  wire logic [5:0]  other_cause_in,
  // Software write of monitor enable
  input  wire logic        monitor_en_wr_in,
  input  wire logic        monitor_en_data_in,
  // Reset pin, open drain
  output logic             reset_pin_out,
  output logic             reset_pin_oe_out,
  // Core reset and restart address
  output logic             core_reset_out,
  output logic [15:0]      restart_addr_out,
  // Data memory clear strobe (never asserted)
  output logic             mem_clear_out,
  // Status
  output logic             monitor_en_out,
  output logic [7:0]       reset_cause_register_out,
  output logic             power_on_flag_out
);

  ////////////////////////////////////////////////////////////////////////
  // State and timer

  reset_seq_pkg::seq_state_e state_reg;
  reset_seq_pkg::seq_state_e state_next;
  logic                      delay_done;
  logic                      delay_run;
  logic                      power_on_pending_reg;
  logic                      hold_next;
  logic                      power_on_exit;
  logic                      non_por_reset;

  // True when the sequencer lets the core run
  function automatic logic is_run(input reset_seq_pkg::seq_state_e st);
    return st == reset_seq_pkg::ST_RUN;
  endfunction

  // True while the supply monitor holds the core
  function automatic logic is_hold(input reset_seq_pkg::seq_state_e st);
    return st == reset_seq_pkg::ST_HOLD;
  endfunction

  // Timer runs only in the release delay state
  assign delay_run = (state_reg == reset_seq_pkg::ST_DELAY);

  release_timer #(
    .DELAY_CYC (reset_seq_pkg::RELEASE_DELAY_CYC)
  ) u_timer (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .run_in   (delay_run),
    .done_out (delay_done)
  );

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      reset_seq_pkg::ST_POWER_UP: begin
        if (supply_ok_in) begin
          state_next = reset_seq_pkg::ST_DELAY;
        end
      end
      reset_seq_pkg::ST_DELAY: begin
        if (!supply_ok_in) begin
          state_next = reset_seq_pkg::ST_POWER_UP;
        end else if (delay_done) begin
          state_next = reset_seq_pkg::ST_RUN;
        end
      end
      reset_seq_pkg::ST_RUN: begin
        if (!supply_ok_in && monitor_en_out) begin
          state_next = reset_seq_pkg::ST_HOLD;
        end
      end
      reset_seq_pkg::ST_HOLD: begin
        if (supply_ok_in) begin
          state_next = reset_seq_pkg::ST_RUN;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= reset_seq_pkg::ST_POWER_UP;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset outputs

  // Reset wanted after this edge: not running, or another source firing
  assign hold_next = !is_run(state_next) || other_reset_in;

  // Open-drain pin driven low while reset is held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_pin_out    <= 1'b0;
      reset_pin_oe_out <= 1'b1;
    end else begin
      reset_pin_out    <= 1'b0;
      reset_pin_oe_out <= hold_next;
    end
  end

  // Core held in reset under the same condition as the pin
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_reset_out <= 1'b1;
    end else begin
      core_reset_out <= hold_next;
    end
  end

  // Restart address is the same for every source
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      restart_addr_out <= reset_seq_pkg::RESTART_ADDR;
    end else begin
      restart_addr_out <= reset_seq_pkg::RESTART_ADDR;
    end
  end

  // No memory initialisation on any reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_clear_out <= 1'b0;
    end else begin
      mem_clear_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply monitor enable

  // Disabled by power-on only, kept across other resets
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      monitor_en_out <= reset_seq_pkg::MONITOR_EN_RESET;
    end else if (monitor_en_wr_in && is_run(state_reg)) begin
      monitor_en_out <= monitor_en_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset cause register

  // Marks a power-on still to be reported; cleared once running, so a
  // later supply-fail recovery is never taken for a power-on exit
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_on_pending_reg <= 1'b1;
    end else if (is_run(state_reg)) begin
      power_on_pending_reg <= 1'b0;
    end
  end

  // Exit from power-on reset, and any other reset source
  assign power_on_exit = power_on_pending_reg && !is_run(state_reg) && is_run(state_next);
  assign non_por_reset = other_reset_in || is_hold(state_reg);

  // Power-on flag: set on power-on exit, cleared by other resets; set wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      power_on_flag_out <= 1'b0;
    end else if (power_on_exit) begin
      power_on_flag_out <= 1'b1;
    end else if (non_por_reset) begin
      power_on_flag_out <= 1'b0;
    end
  end

  // Cause bits: bit 1 resets to 1, then is set and cleared with the flag in the same cycle; bit 0 marks a
  // supply-fail hold, upper bits left as captured while the flag is set
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_cause_register_out <= reset_seq_pkg::CAUSE_RESET;
    end else begin
      if (power_on_exit) begin
        reset_cause_register_out[reset_seq_pkg::POWER_ON_BIT] <= 1'b1;
      end else if (non_por_reset) begin
        reset_cause_register_out[reset_seq_pkg::POWER_ON_BIT] <= 1'b0;
      end
      reset_cause_register_out[0] <= is_hold(state_reg) ? 1'b1 :
                                     (other_reset_in ? 1'b0 : reset_cause_register_out[0]);
      if (other_reset_in) begin
        reset_cause_register_out[7:reset_seq_pkg::CAUSE_OTHER_LO] <= other_cause_in;
      end
    end
  end

endmodule

/* verif/reset_seq_checker.sv */
// Port checker for the power-on and supply-fail reset sequencer.
// Assumes a bind to the sequencer top module, one clock domain.
`timescale 1ns/10ps
module reset_seq_checker (
  // Clock, reset and inputs
  input wire logic        clk_in, rst_in, supply_ok_in, other_reset_in,
  // Outputs watched
  input wire logic        reset_pin_out, reset_pin_oe_out, core_reset_out, mem_clear_out,
  input wire logic        monitor_en_out, power_on_flag_out,
  input wire logic [15:0] restart_addr_out,
  input wire logic [7:0]  reset_cause_register_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////
  // Release and flags
  AST_REL_SUPPLY: assert property ($rose(power_on_flag_out) |-> $past(supply_ok_in)) else $error("released without supply");
  AST_REL_CORE: assert property ($rose(power_on_flag_out) |-> !core_reset_out && $past(core_reset_out))
    else $error("flag and release apart");
  AST_CAUSE: assert property ($rose(power_on_flag_out) |=> reset_cause_register_out[1]) else $error("cause bit1 low");
  AST_CLR: assert property (other_reset_in |=> !power_on_flag_out) else $error("flag kept");
  AST_ADDR: assert property (restart_addr_out == 16'h0000) else $error("restart address");
  AST_MEM: assert property (!mem_clear_out) else $error("memory cleared");
  AST_MON_POR: assert property ($fell(rst_in) |-> !monitor_en_out) else $error("monitor on");
  AST_FAIL: assert property (monitor_en_out && !supply_ok_in && !core_reset_out |=> core_reset_out)
    else $error("no supply-fail hold");
  AST_RECOVER: assert property (core_reset_out && monitor_en_out && supply_ok_in && !$past(supply_ok_in)
    && !power_on_flag_out |=> !core_reset_out) else $error("no recovery");
  AST_PIN: assert property (reset_pin_oe_out == core_reset_out && !reset_pin_out) else $error("pin mismatch");
  AST_KEEP: assert property (other_reset_in |=> $stable(monitor_en_out)) else $error("monitor changed");
  // Main scenarios
  cover property ($rose(power_on_flag_out));
  cover property (other_reset_in);
  cover property (monitor_en_out && $fell(supply_ok_in));
endmodule
bind power_on_and_supply_fail_reset reset_seq_checker chk (.clk_in(clk_in), .rst_in(rst_in),
  .supply_ok_in(supply_ok_in), .other_reset_in(other_reset_in), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_out(reset_pin_oe_out), .core_reset_out(core_reset_out), .mem_clear_out(mem_clear_out),
  .monitor_en_out(monitor_en_out), .power_on_flag_out(power_on_flag_out),
  .restart_addr_out(restart_addr_out), .reset_cause_register_out(reset_cause_register_out));

/* verif/supply_partner.sv */
// Analog side model: supply comparator and pulled-up reset pin.
// Assumes the bench commands the supply level.
`timescale 1ns/10ps
module supply_partner (
  input  wire logic want_ok_in, oe_in, pin_in,
  output logic      supply_ok_out, pin_wire_out
);
  // Comparator follows supply; pin pulled up when released
  assign supply_ok_out = want_ok_in;
  assign pin_wire_out  = oe_in ? pin_in : 1'b1;
endmodule

/* verif/power_on_and_supply_fail_reset_tb_top.sv */
// Bench for the reset sequencer: power-up, other reset, supply fail.
// Assumes the checker is bound and the partner models the analog side.
`timescale 1ns/10ps
module power_on_and_supply_fail_reset_tb_top;
  logic clk_in, rst_in, want_ok, other_reset_in, wr_in, wd_in;
  logic [5:0] cause_in;
  wire supply_ok, pin, pin_oe, pin_wire, core_rst, mem_clr, mon_en, flag;
  wire [15:0] addr;
  wire [7:0] cause;
  int n_errors, compares, i;
  ////////////////////////////////////////////////////////////////
  power_on_and_supply_fail_reset dut (.clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok),
    .other_reset_in(other_reset_in), .other_cause_in(cause_in), .monitor_en_wr_in(wr_in),
    .monitor_en_data_in(wd_in), .reset_pin_out(pin), .reset_pin_oe_out(pin_oe), .core_reset_out(core_rst),
    .restart_addr_out(addr), .mem_clear_out(mem_clr), .monitor_en_out(mon_en),
    .reset_cause_register_out(cause), .power_on_flag_out(flag));
  supply_partner far (.want_ok_in(want_ok), .oe_in(pin_oe), .pin_in(pin), .supply_ok_out(supply_ok),
    .pin_wire_out(pin_wire));
  // Clock and watchdog
  initial begin clk_in = 0; forever #12.5 clk_in = ~clk_in; end
  initial begin #(40000*25); n_errors++; stop_test; end
  task step(input int n); repeat (n) @(posedge clk_in); #2; endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin n_errors++; $display("wrong value %s expected %h seen %h", nm, e, g); end
  endtask
  task t_power_up;
    rst_in = 1; want_ok = 0; step(10); rst_in = 0;
    wr_in = 1; wd_in = 1; step(50); wr_in = 0;
    chk("core", 1, core_rst);
    chk("pin", 0, pin_wire);
    want_ok = 1; i = 0;
    while (core_rst === 1'b1 && i < 13000) begin step(1); i++; end
    chk("delay", 1, i >= reset_seq_pkg::RELEASE_DELAY_CYC && i <= reset_seq_pkg::RELEASE_DELAY_CYC + 4);
    chk("flag", 1, flag);
    chk("addr", 0, addr);
    chk("mon", 0, mon_en);
    chk("mem", 0, mem_clr);
    step(1); chk("cause1", 1, cause[1]);
    $display("test power_up done");
  endtask
  task t_other;
    wr_in = 1; wd_in = 1; step(1); wr_in = 0;
    cause_in = 6'h2a; other_reset_in = 1; step(1); other_reset_in = 0; step(2);
    chk("flag", 0, flag);
    chk("cause", 6'h2a, cause[7:2]);
    chk("mon", 1, mon_en);
    chk("addr", 0, addr);
    $display("test other_reset done");
  endtask
  // Supply drop with the monitor off must be ignored
  task t_monitor_off;
    want_ok = 0; step(3);
    chk("core", 0, core_rst);
    chk("flag", 1, flag);
    want_ok = 1; step(1);
    $display("test monitor_off done");
  endtask
  task t_supply_fail;
    wr_in = 1; wd_in = 1; step(1); wr_in = 0;
    want_ok = 0; step(2);
    chk("core", 1, core_rst);
    chk("pin", 0, pin_wire);
    chk("flag", 0, flag);
    chk("cause0", 1, cause[0]);
    want_ok = 1; step(2);
    chk("core", 0, core_rst);
    chk("mon", 1, mon_en);
    chk("mem", 0, mem_clr);
    $display("test supply_fail done");
  endtask
  task stop_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence, second power-up checks monitor reset
  initial begin
    rst_in = 1; want_ok = 0; other_reset_in = 0; cause_in = 0; wr_in = 0; wd_in = 0;
    n_errors = 0; compares = 0; step(1);
    t_power_up; t_other; t_supply_fail; t_power_up; t_monitor_off; t_supply_fail;
    stop_test;
  end
endmodule
